// ===== dbg_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef DBG_DEFINES_VH
`define DBG_DEFINES_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define DBG_REG_CMD 16'hff00
`define DBG_REG_STAT 16'hff01
`define DBG_REG_SHH 16'hff02
`define DBG_REG_SHL 16'hff03
`define DBG_REG_ADH 16'hff04
`define DBG_REG_ADL 16'hff05
`define DBG_REG_CCR 16'hff06
`define DBG_MAP_BASE 16'hff00
// ----------------------------------------
// instruction register fields
// ----------------------------------------
`define DBG_CMD_HW 7
`define DBG_CMD_DATA 6
`define DBG_CMD_RD 5
`define DBG_CMD_BKG 4
`define DBG_CMD_WORD 3
`define DBG_CMD_MAP 2
`define DBG_CMD_BGND_VAL 8'h90
`define DBG_EXIT_NONE 2'h0
`define DBG_EXIT_GO 2'h1
`define DBG_EXIT_STEP 2'h2
`define DBG_EXIT_TAG 2'h3
`define DBG_REGISTER_SELECT_FIELD_NEXT 3'h2
`define DBG_REGISTER_SELECT_FIELD_PC 3'h3
`define DBG_REGISTER_SELECT_FIELD_D 3'h4
`define DBG_REGISTER_SELECT_FIELD_X 3'h5
`define DBG_REGISTER_SELECT_FIELD_Y 3'h6
`define DBG_REGISTER_SELECT_FIELD_SP 3'h7
// ----------------------------------------
// status register fields
// ----------------------------------------
`define DBG_ST_EN 7
`define DBG_ST_ACT 6
`define DBG_ST_TAG 5
`define DBG_ST_SDV 4
`define DBG_ST_STEP 3
`define DBG_ST_CLK 2
`define DBG_ST_RESET_SPECIAL 8'h40
`define DBG_ST_RESET_NORMAL 8'h00
// ----------------------------------------
// timing counts in logic_tick cycles (idle limit in debug-clock ticks), and the next-word step
// ----------------------------------------
`define DBG_ACT_DELAY 4
`define DBG_TAG_DELAY 16
`define DBG_IDLE_LIMIT 512
`define DBG_NEXT_STEP 16'h0002
`endif

// ===== dbg_delay.v
// fixed-length delayed pulse, restartable
`include "dbg_defines.vh"
module dbg_delay #(
  parameter CYCLES = 4,
  parameter W = 5
) (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire tick,
  // control
  input wire start,
  output reg done
);
  reg [W-1:0] cnt_q;
  reg run_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1};
        run_q <= 1'b1;
      end else if (run_q && tick) begin
        if (cnt_q == {W{1'b0}}) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // dbg_delay

// ===== dbg_regs.v
// debug port register set and command decode
// Overview of operation
// (RULE_01) enable flag gates active mode, firmware commands
// (RULE_02) special modes reset status with active set
// (RULE_03) firmware sets enable flag after special reset; the code sets it at special reset itself
// (RULE_04) active set on entry; cleared four clocks later
// (RULE_05) host avoids next-word writes onto instruction reg
// (RULE_06) tag flag: set by tag-go, delayed sixteen cycles
// (RULE_07) serial commands ignored while tagging
// (RULE_08) shifter-valid shows shift complete
// (RULE_09) single-step command sets step flag
// (RULE_10) clock-select: debug clock or bus clock
// (RULE_11) host times clock-select write at old rate
// (RULE_12) slow bus clock forces bus clock
// (RULE_13) 512 idle cycles clear instruction register
// (RULE_14) instruction bits: hw/fw, data, read, word
// (RULE_15) bit 4 background request, value 0x90
// (RULE_16) bit 2 selects debug map at FF00
// (RULE_17) exit field: go, step, tag-and-go
// (RULE_18) register field selects next, PC, D, X, Y, SP
// (RULE_19) next-word adds two to X first
// (RULE_20) 16-bit shift register, no reset value
// (RULE_21) address register written only by hardware
// (RULE_22) condition codes saved on debug entry
// (RULE_23) per-bit write permissions on status register
// (RULE_24) unused low bits read zero
`include "dbg_defines.vh"
module dbg_regs (
  // clock and reset
  input wire clk,
  input wire rst,
  // mode and clock environment
  input wire special_mode,
  input wire dbg_clk_tick,
  input wire bus_clk_tick,
  input wire bus_clk_slow,
  // parallel register bus
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output wire reg_hit,
  // serial engine side
  input wire ser_cmd_load,
  input wire [7:0] ser_cmd,
  input wire ser_fall_in,
  input wire ser_shift_done,
  input wire [15:0] ser_shift_data,
  input wire ser_addr_load,
  input wire [15:0] ser_addr,
  output wire ser_accept,
  output wire [15:0] shift_out,
  // cpu core side
  input wire enter_debug,
  input wire [7:0] cpu_ccr,
  input wire [15:0] cpu_x,
  output reg [15:0] next_x,
  output reg next_x_valid,
  output wire debug_mapped,
  output wire logic_tick,
  output wire tagging_on,
  output wire cmd_is_hw,
  output wire cmd_has_data,
  output wire cmd_is_read,
  output wire cmd_is_word,
  output wire bgnd_req,
  output wire hw_map_debug,
  output wire [1:0] exit_action_field,
  output wire [2:0] register_select_field,
  output wire do_go,
  output wire do_step,
  output wire do_tag_go,
  output wire sel_next,
  output wire sel_pc,
  output wire sel_d,
  output wire sel_x,
  output wire sel_y,
  output wire sel_sp
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] cmd_q;
  reg debug_enable_flag;
  reg debug_active_flag;
  reg tagging_enable_flag;
  reg shifter_valid_flag;
  reg step_flag;
  reg clock_select_flag;
  reg [15:0] shift_q;
  reg [15:0] addr_q;
  reg [7:0] ccr_q;
  reg tag_live_q;
  reg cmd_new_q;
  reg [9:0] idle_q;
  reg fall_s1_q;
  reg fall_s2_q;
  reg fall_s3_q;
  wire fall_edge;
  wire act_clear_done;
  wire tag_done;
  wire st_wr;
  wire act_wr0;
  // ----------------------------------------
  // clock selection
  // ----------------------------------------
  // slow bus clock overrides the select bit
  assign logic_tick = (clock_select_flag || bus_clk_slow) ? bus_clk_tick
                      : dbg_clk_tick; // see RULE_10 see RULE_12
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function [7:0] one_hot3;
    input [2:0] v;
    begin
      one_hot3 = 8'h01 << v;
    end
  endfunction
  wire [7:0] register_select_field_hot;
  wire [7:0] exit_hot;
  assign register_select_field_hot = one_hot3(cmd_q[2:0]);
  assign exit_hot = one_hot3({1'b0, cmd_q[4:3]});
  assign cmd_is_hw = cmd_q[`DBG_CMD_HW]; // see RULE_14
  assign cmd_has_data = cmd_q[`DBG_CMD_DATA]; // see RULE_14
  assign cmd_is_read = cmd_q[`DBG_CMD_RD]; // see RULE_14
  assign cmd_is_word = cmd_is_hw & cmd_q[`DBG_CMD_WORD]; // see RULE_14
  assign bgnd_req = cmd_is_hw & cmd_q[`DBG_CMD_BKG]; // see RULE_15
  assign hw_map_debug = cmd_is_hw & cmd_q[`DBG_CMD_MAP]; // see RULE_16
  assign exit_action_field = cmd_q[4:3];
  assign register_select_field = cmd_q[2:0];
  // firmware commands only while enabled
  wire fw_ok;
  assign fw_ok = ~cmd_is_hw & debug_enable_flag; // see RULE_01
  assign do_go = fw_ok & exit_hot[`DBG_EXIT_GO]; // see RULE_17
  assign do_step = fw_ok & exit_hot[`DBG_EXIT_STEP]; // see RULE_17
  assign do_tag_go = fw_ok & exit_hot[`DBG_EXIT_TAG]; // see RULE_17
  assign sel_next = fw_ok & register_select_field_hot[`DBG_REGISTER_SELECT_FIELD_NEXT]; // see RULE_18
  assign sel_pc = fw_ok & register_select_field_hot[`DBG_REGISTER_SELECT_FIELD_PC]; // see RULE_18
  assign sel_d = fw_ok & register_select_field_hot[`DBG_REGISTER_SELECT_FIELD_D]; // see RULE_18
  assign sel_x = fw_ok & register_select_field_hot[`DBG_REGISTER_SELECT_FIELD_X]; // see RULE_18
  assign sel_y = fw_ok & register_select_field_hot[`DBG_REGISTER_SELECT_FIELD_Y]; // see RULE_18
  assign sel_sp = fw_ok & register_select_field_hot[`DBG_REGISTER_SELECT_FIELD_SP]; // see RULE_18
  // ----------------------------------------
  // serial gate and map
  // ----------------------------------------
  assign tagging_on = tag_live_q;
  assign ser_accept = ~tag_live_q; // see RULE_07
  assign debug_mapped = debug_active_flag; // see RULE_04
  assign shift_out = shift_q;
  assign reg_hit = debug_active_flag &&
                   (reg_addr >= `DBG_REG_CMD) && (reg_addr <= `DBG_REG_CCR);
  assign st_wr = reg_wr && reg_hit && (reg_addr == `DBG_REG_STAT);
  // active flag may only be written under a firmware command
  assign act_wr0 = st_wr && ~cmd_is_hw && ~reg_wdata[`DBG_ST_ACT]; // see RULE_23
  // ----------------------------------------
  // delayed effects
  // ----------------------------------------
  dbg_delay #(.CYCLES(`DBG_ACT_DELAY), .W(5)) u_act_delay (
    .clk(clk),
    .rst(rst),
    .tick(logic_tick),
    .start(act_wr0),
    .done(act_clear_done)
  ); // see RULE_04
  dbg_delay #(.CYCLES(`DBG_TAG_DELAY), .W(5)) u_tag_delay (
    .clk(clk),
    .rst(rst),
    .tick(logic_tick),
    .start(do_tag_go & cmd_new_q),
    .done(tag_done)
  ); // see RULE_06
  // ----------------------------------------
  // host falling-edge synchroniser
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fall_s1_q <= 1'b0;
      fall_s2_q <= 1'b0;
      fall_s3_q <= 1'b0;
    end else begin
      fall_s1_q <= ser_fall_in;
      fall_s2_q <= fall_s1_q;
      fall_s3_q <= fall_s2_q;
    end
  end
  assign fall_edge = fall_s3_q & ~fall_s2_q;
  // ----------------------------------------
  // instruction register and idle timer
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q <= 8'h00;
      idle_q <= 10'h000;
      cmd_new_q <= 1'b0;
    end else begin
      // actions decode the stored command, so they wait one cycle after load
      cmd_new_q <= ser_cmd_load && ser_accept; // see RULE_07
      if (fall_edge) begin
        idle_q <= 10'h000;
      end else if (dbg_clk_tick && idle_q != `DBG_IDLE_LIMIT) begin
        idle_q <= idle_q + 10'h001;
      end
      if (idle_q == `DBG_IDLE_LIMIT - 1 && dbg_clk_tick && !fall_edge) begin
        cmd_q <= 8'h00; // see RULE_13
      end else if (ser_cmd_load && ser_accept) begin
        // hardware form keeps low bits clear
        cmd_q <= ser_cmd[7] ? {ser_cmd[7:2], 2'h0} : ser_cmd; // see RULE_24
      end else if (reg_wr && reg_hit && reg_addr == `DBG_REG_CMD) begin
        cmd_q <= reg_wdata[7] ? {reg_wdata[7:2], 2'h0} : reg_wdata;
      end
    end
  end
  // ----------------------------------------
  // status register
  // ----------------------------------------
  reg special_seen_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      debug_enable_flag <= 1'b0;
      debug_active_flag <= 1'b0;
      tagging_enable_flag <= 1'b0;
      shifter_valid_flag <= 1'b0;
      step_flag <= 1'b0;
      clock_select_flag <= 1'b0;
      tag_live_q <= 1'b0;
      special_seen_q <= 1'b0;
    end else begin
      // reset value depends on mode, caught after release
      if (!special_seen_q) begin
        special_seen_q <= 1'b1;
        debug_active_flag <= special_mode; // see RULE_02
        debug_enable_flag <= special_mode; // see RULE_03
      end else begin
        if (st_wr) begin
          debug_enable_flag <= reg_wdata[`DBG_ST_EN]; // see RULE_23
          tagging_enable_flag <= reg_wdata[`DBG_ST_TAG];
          step_flag <= reg_wdata[`DBG_ST_STEP];
          if (cmd_is_hw) begin
            clock_select_flag <= reg_wdata[`DBG_ST_CLK]; // see RULE_23
          end
          if (!cmd_is_hw && reg_wdata[`DBG_ST_ACT]) begin
            debug_active_flag <= 1'b1;
          end
        end
        if (ser_cmd_load && ser_accept && ser_cmd == `DBG_CMD_BGND_VAL) begin
          shifter_valid_flag <= 1'b0;
        end
        // data valid wins over a firmware clear
        if (ser_shift_done) begin
          shifter_valid_flag <= 1'b1; // see RULE_08
        end else if (st_wr) begin
          shifter_valid_flag <= reg_wdata[`DBG_ST_SDV];
        end
        if (do_step & cmd_new_q) begin
          step_flag <= 1'b1; // see RULE_09
        end
        if (do_tag_go & cmd_new_q) begin
          tagging_enable_flag <= 1'b1; // see RULE_06
        end
        if (tag_done) begin
          tag_live_q <= 1'b1; // see RULE_06
        end
        if (act_clear_done) begin
          debug_active_flag <= 1'b0; // see RULE_04
        end
        // entry beats a clear landing in the same cycle
        if (enter_debug && debug_enable_flag) begin
          debug_active_flag <= 1'b1; // see RULE_01 see RULE_04
          tagging_enable_flag <= 1'b0; // see RULE_06
          tag_live_q <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------
  // shifter, address, saved condition codes
  // ----------------------------------------
  // no reset on data words: contents undefined until loaded
  always @(posedge clk) begin
    if (ser_shift_done) begin
      shift_q <= ser_shift_data; // see RULE_20
    end else if (reg_wr && reg_hit && reg_addr == `DBG_REG_SHH) begin
      shift_q[15:8] <= reg_wdata;
    end else if (reg_wr && reg_hit && reg_addr == `DBG_REG_SHL) begin
      shift_q[7:0] <= reg_wdata;
    end
    if (ser_addr_load) begin
      addr_q <= ser_addr; // see RULE_21
    end
    if (enter_debug && debug_enable_flag) begin
      ccr_q <= cpu_ccr; // see RULE_22
    end else if (reg_wr && reg_hit && reg_addr == `DBG_REG_CCR) begin
      ccr_q <= reg_wdata; // see RULE_22
    end
  end
  // ----------------------------------------
  // next-word pointer
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      next_x <= 16'h0000;
      next_x_valid <= 1'b0;
    end else begin
      next_x_valid <= sel_next & cmd_new_q;
      if (sel_next & cmd_new_q) begin
        next_x <= cpu_x + `DBG_NEXT_STEP; // see RULE_19
      end
    end
  end
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_hit) begin
      case (reg_addr)
        `DBG_REG_CMD: reg_rdata <= cmd_q;
        `DBG_REG_STAT: reg_rdata <= {debug_enable_flag, debug_active_flag,
                                     tagging_enable_flag, shifter_valid_flag,
                                     step_flag, clock_select_flag, 2'h0}; // see RULE_24
        `DBG_REG_SHH: reg_rdata <= shift_q[15:8];
        `DBG_REG_SHL: reg_rdata <= shift_q[7:0];
        `DBG_REG_ADH: reg_rdata <= addr_q[15:8]; // see RULE_21
        `DBG_REG_ADL: reg_rdata <= addr_q[7:0];
        `DBG_REG_CCR: reg_rdata <= ccr_q;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // dbg_regs

// ===== dbg_regs_assertions.sv
// concurrent checks on the debug port register block
module dbg_regs_assertions (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched ports
  input wire [15:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_hit,
  input wire bus_clk_tick,
  input wire bus_clk_slow,
  input wire logic_tick,
  input wire ser_shift_done,
  input wire [15:0] ser_shift_data,
  input wire ser_accept,
  input wire [15:0] shift_out,
  input wire tagging_on,
  input wire enter_debug,
  input wire [15:0] cpu_x,
  input wire [15:0] next_x,
  input wire next_x_valid,
  input wire debug_mapped,
  input wire cmd_is_hw,
  input wire bgnd_req,
  input wire hw_map_debug,
  input wire do_go,
  input wire [1:0] exit_action_field,
  input wire sel_next,
  input wire [2:0] register_select_field
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  reg_hit_a: assert property (
    reg_hit |-> debug_mapped && reg_addr >= 16'hff00 && reg_addr <= 16'hff06)
    else $error("register hit outside mapped window");
  ser_gate_a: assert property (ser_accept == !tagging_on)
    else $error("serial accept not the inverse of tagging");
  slow_clk_a: assert property (
    bus_clk_slow |-> logic_tick == bus_clk_tick)
    else $error("slow bus clock not forcing bus tick");
  next_word_a: assert property (
    next_x_valid |-> next_x == cpu_x + 16'h0002)
    else $error("next word address not index plus two");
  bgnd_hw_a: assert property ((bgnd_req || hw_map_debug) |-> cmd_is_hw)
    else $error("background or map flag on firmware command");
  exit_go_a: assert property (
    do_go |-> !cmd_is_hw && exit_action_field == 2'h1)
    else $error("resume decode wrong");
  sel_next_a: assert property (
    sel_next |-> !cmd_is_hw && register_select_field == 3'h2)
    else $error("next word select decode wrong");
  low_zero_a: assert property (
    reg_rd && reg_addr == 16'hff01 |=> reg_rdata[1:0] == 2'b00)
    else $error("status low bits not zero");
  refuse_rd_a: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("refused read returned data");
  shift_load_a: assert property (
    ser_shift_done && ser_accept |=> shift_out == $past(ser_shift_data))
    else $error("shifter did not take serial data");
  entry_tag_a: assert property (enter_debug |-> ##[1:2] !tagging_on)
    else $error("tagging not cleared on debug entry");
  // ----------------------------------------
  // covers
  // ----------------------------------------
  cover property (bgnd_req);
  cover property (tagging_on);
  cover property ($fell(debug_mapped));
  cover property (next_x_valid);
endmodule // dbg_regs_assertions

bind dbg_regs dbg_regs_assertions u_chk (.*);

// ===== dbg_host_model.sv
// behavioural debug host driving the serial engine side
module dbg_host_model (
  // clock
  input wire logic clk,
  // serial engine inputs
  output logic ser_cmd_load,
  output logic [7:0] ser_cmd,
  output logic ser_fall_in,
  output logic ser_shift_done,
  output logic [15:0] ser_shift_data,
  output logic ser_addr_load,
  output logic [15:0] ser_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ser_cmd_load, ser_fall_in, ser_shift_done, ser_addr_load} = 4'h0;
    ser_cmd = 8'h00;
    ser_shift_data = 16'h0000;
    ser_addr = 16'h0000;
  end
  // never a next-word write aimed at the command register address
  task send(input logic [7:0] op);
    @(negedge clk);
    ser_cmd = op;
    ser_cmd_load = 1;
    ser_fall_in = 1;
    @(negedge clk);
    ser_cmd_load = 0;
    ser_fall_in = 0;
    ser_cmd = ~op;
  endtask
  // released lines show the inverse, not a stale copy
  task shift(input logic [15:0] d, input logic [15:0] a);
    @(negedge clk);
    ser_shift_data = d;
    ser_addr = a;
    ser_shift_done = 1;
    ser_addr_load = 1;
    @(negedge clk);
    ser_shift_done = 0;
    ser_addr_load = 0;
    ser_shift_data = ~d;
    ser_addr = ~a;
  endtask
endmodule // dbg_host_model

// ===== debug_mode_register_decode_bench.sv
// self-checking bench for the debug port register block
module debug_mode_register_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, special_mode = 1, dbg_clk_tick = 0, bus_clk_tick = 0;
  logic bus_clk_slow = 0, reg_wr = 0, reg_rd = 0, enter_debug = 0;
  logic [15:0] reg_addr = 16'h0000, cpu_x = 16'h1234;
  logic [7:0] reg_wdata = 8'h00, cpu_ccr = 8'h5a, reg_rdata, ser_cmd;
  logic reg_hit, ser_cmd_load, ser_fall_in, ser_shift_done, ser_addr_load, ser_accept;
  logic [15:0] ser_shift_data, ser_addr, shift_out, next_x;
  logic next_x_valid, debug_mapped, logic_tick, tagging_on, cmd_is_hw, cmd_has_data;
  logic cmd_is_read, cmd_is_word, bgnd_req, hw_map_debug, do_go, do_step, do_tag_go;
  logic [1:0] exit_action_field;
  logic [2:0] register_select_field;
  logic sel_next, sel_pc, sel_d, sel_x, sel_y, sel_sp;
  int bad_count = 0, cmp_count = 0, tk = 0;
  always #5 clk = ~clk;
  // ticks: debug every 2 cycles, bus every 3
  always @(negedge clk) begin
    tk <= tk + 1;
    dbg_clk_tick <= (tk % 2 == 0);
    bus_clk_tick <= (tk % 3 == 0);
  end
  dbg_host_model h (.*);
  dbg_regs dut (.*);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(logic [15:0] a, logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
    reg_wdata = ~d;
  endtask
  task rdchk(logic [15:0] a, logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    chk("rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task enter;
    @(negedge clk);
    enter_debug = 1;
    @(negedge clk);
    enter_debug = 0;
  endtask
  task hwc(logic [7:0] op, logic [5:0] dec, logic [7:0] rb);
    h.send(op);
    chk("decode", dec, {cmd_is_hw, cmd_has_data, cmd_is_read, bgnd_req, cmd_is_word,
      hw_map_debug});
    rdchk(16'hff00, rb);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_hw;
    hwc(8'h90, 6'b100100, 8'h90);
    hwc(8'he4, 6'b111001, 8'he4);
    hwc(8'hcb, 6'b110010, 8'hc8);
  endtask
  task t_fw;
    for (int e = 0; e < 3; e++) begin
      h.send({3'b000, e[1:0], 3'b000});
      chk("exit", (e == 0) ? 3'b000 : 3'b100 >> (e - 1), {do_go, do_step, do_tag_go});
    end
    for (int r = 0; r < 8; r++) begin
      h.send({3'b010, 2'b00, r[2:0]});
      chk("regsel", (r < 2) ? 6'h00 : 6'b100000 >> (r - 2),
        {sel_next, sel_pc, sel_d, sel_x, sel_y, sel_sp});
    end
    rdchk(16'hff01, 8'hc8);
  endtask
  task t_next;
    cpu_x = 16'h2468;
    h.send(8'h42);
    for (int i = 0; i < 20 && next_x_valid !== 1'b1; i++) @(negedge clk);
    chk("next_x", 16'h246a, next_x);
  endtask
  task t_shift;
    h.shift(16'ha5c3, 16'h1357);
    rdchk(16'hff02, 8'ha5);
    rdchk(16'hff03, 8'hc3);
    rdchk(16'hff01, 8'hd8);
    wr(16'hff04, 8'h00);
    rdchk(16'hff04, 8'h13);
    rdchk(16'hff05, 8'h57);
    rdchk(16'hff07, 8'h00);
  endtask
  task t_act;
    h.send(8'h90);
    wr(16'hff01, 8'h80);
    repeat (14) @(negedge clk);
    chk("mapped hw", 1'b1, debug_mapped);
    h.send(8'h63);
    wr(16'hff01, 8'h80);
    repeat (4) @(negedge clk);
    chk("mapped early", 1'b1, debug_mapped);
    repeat (8) @(negedge clk);
    chk("mapped late", 1'b0, debug_mapped);
    rdchk(16'hff06, 8'h00);
    cpu_ccr = 8'h96;
    enter;
    rdchk(16'hff06, 8'h96);
    wr(16'hff06, 8'h3c);
    rdchk(16'hff06, 8'h3c);
  endtask
  task t_idle;
    h.send(8'h90);
    repeat (900) @(negedge clk);
    rdchk(16'hff00, 8'h90);
    repeat (200) @(negedge clk);
    rdchk(16'hff00, 8'h00);
  endtask
  task tkchk(logic use_bus);
    repeat (6) begin
      @(posedge clk);
      #1;
      chk("tick", use_bus ? bus_clk_tick : dbg_clk_tick, logic_tick);
    end
    @(negedge clk);
  endtask
  task t_clk;
    tkchk(1'b0);
    bus_clk_slow = 1;
    tkchk(1'b1);
    bus_clk_slow = 0;
    h.send(8'h90);
    wr(16'hff01, 8'h84);
    // 150 ticks at the old debug rate before the next command
    repeat (300) @(negedge clk);
    tkchk(1'b1);
    bus_clk_slow = 1;
    tkchk(1'b1);
    bus_clk_slow = 0;
  endtask
  task t_tag;
    h.send(8'h18);
    repeat (20) @(negedge clk);
    chk("tag early", 1'b0, tagging_on);
    repeat (40) @(negedge clk);
    chk("tag late", 1'b1, tagging_on);
    h.send(8'h90);
    chk("ignored", 1'b0, bgnd_req);
    enter;
    chk("tag clear", 1'b0, tagging_on);
  endtask
  task t_norm;
    @(negedge clk);
    rst = 1;
    special_mode = 0;
    repeat (5) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    chk("mapped norm", 1'b0, debug_mapped);
    rdchk(16'hff01, 8'h00);
    enter;
    chk("entry refused", 1'b0, debug_mapped);
    h.send(8'h08);
    chk("fw refused", 1'b0, do_go);
    h.send(8'h90);
    chk("hw kept", 1'b1, bgnd_req);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    rdchk(16'hff01, 8'hc0);
    t_hw;
    t_fw;
    t_next;
    t_shift;
    t_act;
    t_idle;
    t_clk;
    t_tag;
    t_norm;
    summarize;
  end
  // a run needs about 1600 cycles
  initial begin
    #100us;
    bad_count++;
    summarize;
  end
endmodule // debug_mode_register_decode_bench
